// File: design/pism_cfg.svh
// Register offsets, field positions, reset values and widths for the input select block.
// Assumes inclusion by bare name from design files of this block.
`ifndef PISM_CFG_SVH
`define PISM_CFG_SVH
`define PISM_OFS_XTAL      12'h000
`define PISM_OFS_INSEL     12'h0B8
`define PISM_OFS_TMRSRC    12'h0BC
`define PISM_OFS_TMRSEL2   12'h0C0
`define PISM_OFS_P0DRV     12'h0E8
`define PISM_RST_XTAL      32'h0000_0032
`define PISM_RST_ZERO      32'h0000_0000
`define PISM_MASK_XTAL     32'h0000_0033
`define PISM_MASK_INSEL    32'h0007_00FF
`define PISM_MASK_TMRSRC   32'h0000_00C0
`define PISM_MASK_TMRSEL2  32'h0000_0FFF
`define PISM_MASK_P0DRV    32'h0777_7777
`define PISM_BIT_SLV_OUT   18
`define PISM_BIT_MST_OUT   17
`define PISM_BIT_MST_CLK   16
`define PISM_BIT_TX_DISC   7
`define PISM_BIT_RX_PICK   6
`define PISM_BIT_T21_CTRL  7
`define PISM_BIT_T2_CTRL   6
`define PISM_BIT_HYS_ON    1
`define PISM_BIT_PINS_ON   0
`define PISM_ADDR_W        12
`endif

// File: design/pism_pkg.sv
// Types shared by the input select block.
// Assumes nothing beyond a SystemVerilog compiler.
package pism_pkg;
  typedef enum logic [1:0] {
    PISM_DRV_STRONG,
    PISM_DRV_MEDIUM,
    PISM_DRV_WEAK
  } pism_drv_t;
  typedef struct packed {
    logic [3:0] ext_irq_zero;
    logic [3:0] ext_irq_one;
    logic [3:0] ext_irq_two;
    logic [1:0] uart_rx;
    logic       uart_tx;
    logic [1:0] serial_slave_out;
    logic [1:0] serial_master_out;
    logic [1:0] serial_master_clock;
    logic [3:0] timer2_ext_pin;
    logic [3:0] timer21_ext_pin;
    logic [3:0] monitor;
    logic       lin_rx;
    logic [3:0] compare_out;
    logic [2:0] capture;
    logic [2:0] timer2_count;
    logic [2:0] timer21_count;
  } pism_src_t;
  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_one;
    logic ext_irq_two;
    logic uart_rx;
    logic lin_tx;
    logic serial_slave_out;
    logic serial_master_out;
    logic serial_master_clock;
    logic timer2_external_input;
    logic timer21_external_input;
    logic timer2_count;
    logic timer21_count;
  } pism_route_t;
endpackage

// File: design/pism_sync.sv
// Two-stage synchroniser for a vector of pin-side levels.
// Assumes the inputs are asynchronous to clk_sys_in.
`timescale 1ns/1ps
module pism_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;
  // A zero-width vector cannot be built, so elaboration refuses it.
  if (WIDTH < 1) begin : g_width_check
    $error("pism_sync width must be at least one");
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// File: design/pism_top.sv
// Peripheral input select and port drive control with an Avalon-MM register slave.
// Assumes pin-side sources are asynchronous; routed outputs are registered on clk_sys_in.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pism_cfg.svh"
module pism_top #(
  parameter int PINS = 7
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      rstn_in,
  input  wire logic [`PISM_ADDR_W-1:0]   avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  output logic      [1:0]                avs_response_out,
  input  wire pism_pkg::pism_src_t       src_in,
  output pism_pkg::pism_route_t          route_out,
  output logic                           uart_tx_line_on_out,
  output logic      [1:0]                crystal_hysteresis_level_out,
  output logic                           crystal_hysteresis_on_out,
  output logic                           crystal_pins_on_out,
  output logic      [3*PINS-1:0]         driver_mode_field_out,
  output logic      [2*PINS-1:0]         driver_strength_out,
  output logic      [2*PINS-1:0]         driver_edge_out
);
  // The driver mode register holds seven pin fields, so more pins cannot be served.
  if (PINS < 1 || PINS > 7) begin : g_pins_check
    $error("pism_top serves one to seven port 0 pins");
  end

  logic [31:0] crystal_pin_control;
  logic [31:0] peripheral_input_select;
  logic [31:0] timer_external_source_control;
  logic [31:0] timer_input_select_two;
  logic [31:0] port0_driver_mode;
  logic        busy;
  logic [31:0] be_mask;
  logic        hit;
  logic [31:0] next_rdata;
  pism_pkg::pism_src_t   src_s;
  pism_pkg::pism_route_t next_route;

  pism_sync #(
    .WIDTH($bits(pism_pkg::pism_src_t))
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .d_in       (src_in),
    .q_out      (src_s)
  );

  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  always_comb begin
    hit        = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (avs_address_in)
      `PISM_OFS_XTAL:    next_rdata = crystal_pin_control;
      `PISM_OFS_INSEL:   next_rdata = peripheral_input_select;
      `PISM_OFS_TMRSRC:  next_rdata = timer_external_source_control;
      `PISM_OFS_TMRSEL2: next_rdata = timer_input_select_two;
      `PISM_OFS_P0DRV:   next_rdata = port0_driver_mode;
      default:           hit = 1'b0;
    endcase
  end

  // Every access takes two cycles: waitrequest is high on the first and low on the second.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy <= 1'b0;
    end else begin
      busy <= (avs_read_in || avs_write_in) && !busy;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      avs_response_out    <= 2'h0;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !busy);
      if ((avs_read_in || avs_write_in) && !busy) begin
        avs_readdata_out <= avs_read_in ? next_rdata : 32'h0000_0000;
        avs_response_out <= hit ? 2'h0 : 2'h3;
      end
    end
  end

  // Writes land at the accepting edge; masks keep reserved bits at zero.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crystal_pin_control           <= `PISM_RST_XTAL;
      peripheral_input_select       <= `PISM_RST_ZERO;
      timer_external_source_control <= `PISM_RST_ZERO;
      timer_input_select_two        <= `PISM_RST_ZERO;
      port0_driver_mode             <= `PISM_RST_ZERO;
    end else if (avs_write_in && busy) begin
      unique case (avs_address_in)
        `PISM_OFS_XTAL: crystal_pin_control <= ((crystal_pin_control & ~be_mask) |
          (avs_writedata_in & be_mask)) & `PISM_MASK_XTAL;
        `PISM_OFS_INSEL: peripheral_input_select <= ((peripheral_input_select & ~be_mask) |
          (avs_writedata_in & be_mask)) & `PISM_MASK_INSEL;
        `PISM_OFS_TMRSRC: timer_external_source_control <=
          ((timer_external_source_control & ~be_mask) |
          (avs_writedata_in & be_mask)) & `PISM_MASK_TMRSRC;
        `PISM_OFS_TMRSEL2: timer_input_select_two <= ((timer_input_select_two & ~be_mask) |
          (avs_writedata_in & be_mask)) & `PISM_MASK_TMRSEL2;
        `PISM_OFS_P0DRV: port0_driver_mode <= ((port0_driver_mode & ~be_mask) |
          (avs_writedata_in & be_mask)) & `PISM_MASK_P0DRV;
        default: begin
        end
      endcase
    end
  end

  // Timer 2 external map; the reserved slot drives a quiet zero.
  function automatic logic t2_ext(input logic [1:0] grp, input logic [1:0] pick,
                                  input pism_pkg::pism_src_t s);
    logic r;
    r = 1'b0;
    unique case (grp)
      2'h0: r = s.timer2_ext_pin[pick];
      2'h1: r = s.monitor[pick];
      2'h2: r = (pick == 2'h0) ? s.lin_rx : (pick == 2'h1) ? 1'b0 :
                (pick == 2'h2) ? s.compare_out[0] : s.compare_out[1];
      2'h3: r = (pick == 2'h3) ? s.capture[2] : s.capture[pick];
    endcase
    return r;
  endfunction

  function automatic logic t21_ext(input logic [1:0] grp, input logic [1:0] pick,
                                   input pism_pkg::pism_src_t s);
    logic r;
    r = 1'b0;
    unique case (grp)
      2'h0: r = s.timer21_ext_pin[pick];
      2'h1: r = s.monitor[pick];
      2'h2: r = (pick == 2'h0) ? s.lin_rx : (pick == 2'h1) ? 1'b0 :
                (pick == 2'h2) ? s.capture[0] : s.capture[1];
      2'h3: r = s.compare_out[pick];
    endcase
    return r;
  endfunction

  always_comb begin
    next_route = '0;
    next_route.ext_irq_zero = src_s.ext_irq_zero[peripheral_input_select[1:0]];
    next_route.ext_irq_one  = src_s.ext_irq_one[peripheral_input_select[3:2]];
    next_route.ext_irq_two  = src_s.ext_irq_two[peripheral_input_select[5:4]];
    next_route.uart_rx = src_s.uart_rx[peripheral_input_select[`PISM_BIT_RX_PICK]];
    // Once the UART path is cut, the link is held at a constant one.
    next_route.lin_tx = peripheral_input_select[`PISM_BIT_TX_DISC] ? 1'b1 : src_s.uart_tx;
    next_route.serial_slave_out =
      src_s.serial_slave_out[peripheral_input_select[`PISM_BIT_SLV_OUT]];
    next_route.serial_master_out =
      src_s.serial_master_out[peripheral_input_select[`PISM_BIT_MST_OUT]];
    next_route.serial_master_clock =
      src_s.serial_master_clock[peripheral_input_select[`PISM_BIT_MST_CLK]];
    next_route.timer2_external_input =
      timer_external_source_control[`PISM_BIT_T2_CTRL] ? src_s.capture[0] :
      t2_ext(timer_input_select_two[9:8], timer_input_select_two[5:4], src_s);
    next_route.timer21_external_input =
      timer_external_source_control[`PISM_BIT_T21_CTRL] ? src_s.compare_out[0] :
      t21_ext(timer_input_select_two[11:10], timer_input_select_two[7:6], src_s);
    // Reserved count codes give a quiet zero rather than an undefined source.
    next_route.timer2_count = (timer_input_select_two[1:0] == 2'h3) ? 1'b0 :
      src_s.timer2_count[timer_input_select_two[1:0]];
    next_route.timer21_count = (timer_input_select_two[3:2] == 2'h3) ? 1'b0 :
      src_s.timer21_count[timer_input_select_two[3:2]];
  end

  // Outputs are registered so a select change never glitches a downstream peripheral.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      route_out <= '0;
    end else begin
      route_out <= next_route;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      uart_tx_line_on_out          <= 1'b0;
      crystal_hysteresis_level_out <= 2'h3;
      crystal_hysteresis_on_out    <= 1'b1;
      crystal_pins_on_out          <= 1'b0;
    end else begin
      // Transmit pin is on while the receive pick is zero; the port mux still needs setup.
      uart_tx_line_on_out <= !peripheral_input_select[`PISM_BIT_RX_PICK];
      crystal_hysteresis_level_out <= crystal_pin_control[5:4];
      crystal_hysteresis_on_out <= crystal_pin_control[`PISM_BIT_HYS_ON];
      crystal_pins_on_out <= crystal_pin_control[`PISM_BIT_PINS_ON];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      driver_mode_field_out <= '0;
      driver_strength_out   <= '0;
      driver_edge_out       <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        driver_mode_field_out[3*i +: 3] <= port0_driver_mode[4*i +: 3];
        unique case (port0_driver_mode[4*i +: 3])
          3'h0, 3'h1, 3'h2: begin
            driver_strength_out[2*i +: 2] <= pism_pkg::PISM_DRV_STRONG;
            driver_edge_out[2*i +: 2]     <= port0_driver_mode[4*i +: 2];
          end
          3'h3, 3'h7: begin
            driver_strength_out[2*i +: 2] <= pism_pkg::PISM_DRV_WEAK;
            driver_edge_out[2*i +: 2]     <= 2'h0;
          end
          default: begin
            driver_strength_out[2*i +: 2] <= pism_pkg::PISM_DRV_MEDIUM;
            driver_edge_out[2*i +: 2]     <= 2'h0;
          end
        endcase
      end
    end
  end

  chk_route_irq_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 route_out.ext_irq_zero == $past(src_s.ext_irq_zero[peripheral_input_select[1:0]]))
    else $error("External interrupt zero route mismatch.");
  chk_route_irq_two: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 route_out.ext_irq_two == $past(src_s.ext_irq_two[peripheral_input_select[5:4]]))
    else $error("External interrupt two route mismatch.");
  chk_serial_clk_sel: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 route_out.serial_master_clock ==
      $past(src_s.serial_master_clock[peripheral_input_select[16]]))
    else $error("Serial clock source mismatch.");
  chk_t2_override: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    timer_external_source_control[6] |=> route_out.timer2_external_input == $past(src_s.capture[0]))
    else $error("Timer 2 override not applied.");
  chk_t21_override: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    timer_external_source_control[7] |=>
      route_out.timer21_external_input == $past(src_s.compare_out[0]))
    else $error("Timer 21 override not applied.");
  chk_t2_count_rsv: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    timer_input_select_two[1:0] == 2'h3 |=> !route_out.timer2_count)
    else $error("Reserved timer 2 count code not quiet.");
  chk_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (peripheral_input_select & ~`PISM_MASK_INSEL) == 32'h0000_0000 &&
    (port0_driver_mode & ~`PISM_MASK_P0DRV) == 32'h0000_0000)
    else $error("Reserved bits became set.");
  chk_weak_mode: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    port0_driver_mode[2:0] == 3'h7 |=> driver_strength_out[1:0] == pism_pkg::PISM_DRV_WEAK)
    else $error("Mode seven not weak.");
  chk_pins_enable: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !crystal_pin_control[0] |=> !crystal_pins_on_out)
    else $error("Crystal pins on while disabled.");
  chk_bus_answer: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[0:2] !avs_waitrequest_out)
    else $error("Bus answer too slow.");
endmodule

// File: tb/pism_far_model.sv
// Far-side model: on-chip peripherals and port pins that feed candidate levels.
// Assumes the bench asks for a new set of levels one edge before it is needed.
`timescale 1ns/1ps
module pism_far_model (
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  input  wire logic                load_in,
  input  wire pism_pkg::pism_src_t value_in,
  output pism_pkg::pism_src_t      src_out
);
  // Levels stay put between loads, so each check sees one stable set of sources.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_out <= '0;
    end else if (load_in) begin
      src_out <= value_in;
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the input select block with a queued scoreboard.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ps
`include "pism_cfg.svh"
module tb_top;
  logic                    clk_sys_in = 1'b0;
  logic                    rstn_in = 1'b0;
  logic [11:0]             addr = 12'h000;
  logic                    rd = 1'b0;
  logic                    wr = 1'b0;
  logic [31:0]             wdata = 32'h0;
  logic [3:0]              be = 4'hF;
  logic [31:0]             rdata;
  logic                    wait_rq;
  logic [1:0]              resp;
  logic                    load = 1'b0;
  logic                    snap = 1'b0;
  pism_pkg::pism_src_t     src_sh = '0;
  pism_pkg::pism_src_t     src;
  pism_pkg::pism_route_t   route;
  logic                    line_on;
  logic                    hys_on;
  logic                    pins_on;
  logic [1:0]              hys_lvl;
  logic [20:0]             mode;
  logic [13:0]             strength;
  logic [13:0]             edge_sh;
  logic [65:0]             exp_q[$];
  logic [65:0]             exp_v;
  logic [31:0]             r_in;
  logic [31:0]             r_ts;
  logic [31:0]             r_t2;
  logic [31:0]             r_x;
  logic [31:0]             r_d;
  logic [31:0]             d;
  logic [63:0]             rnd;
  logic [11:0]             offs [5] = '{`PISM_OFS_XTAL, `PISM_OFS_INSEL, `PISM_OFS_TMRSRC,
                                        `PISM_OFS_TMRSEL2, `PISM_OFS_P0DRV};
  int                      fail_count = 0;
  int                      check_count = 0;
  int                      seed = 38;

  always #2.5 clk_sys_in = ~clk_sys_in;

  pism_top uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .avs_response_out(resp),
    .src_in(src), .route_out(route), .uart_tx_line_on_out(line_on),
    .crystal_hysteresis_level_out(hys_lvl), .crystal_hysteresis_on_out(hys_on),
    .crystal_pins_on_out(pins_on), .driver_mode_field_out(mode),
    .driver_strength_out(strength), .driver_edge_out(edge_sh));

  pism_far_model far (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .load_in(load),
    .value_in(src_sh), .src_out(src));

  task automatic check(input logic [65:0] seen, input logic [65:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read results are sampled at the rising edge where waitrequest is seen low, snapshots at the edge where snap is set, before that edge updates them.
  always @(posedge clk_sys_in) begin
    if ((rd && !wait_rq) || snap) begin
      if (exp_q.size() == 0) begin
        exp_v = 66'h0;
        fail_count++;
        $display("unexpected at %0t: result with no expected value queued", $time);
      end else begin
        exp_v = exp_q.pop_front();
      end
      if (snap) begin
        check({strength, edge_sh, mode, route, line_on, hys_lvl, hys_on, pins_on}, exp_v);
      end else begin
        check({32'h0, resp, rdata}, exp_v);
      end
    end
  end

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dt,
                     input logic [3:0] b);
    int n;
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= dt;
    be <= b;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    if (wait_rq !== 1'b0) begin
      fail_count++;
      tally_and_finish();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                        input logic [3:0] b, input logic [31:0] k);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    return (o & ~m) | (v & m & k);
  endfunction

  task automatic wreg(input logic [11:0] a, input logic [31:0] v, input logic [3:0] b);
    case (a)
      `PISM_OFS_XTAL:    r_x  = merge(r_x, v, b, `PISM_MASK_XTAL);
      `PISM_OFS_INSEL:   r_in = merge(r_in, v, b, `PISM_MASK_INSEL);
      `PISM_OFS_TMRSRC:  r_ts = merge(r_ts, v, b, `PISM_MASK_TMRSRC);
      `PISM_OFS_TMRSEL2: r_t2 = merge(r_t2, v, b, `PISM_MASK_TMRSEL2);
      `PISM_OFS_P0DRV:   r_d  = merge(r_d, v, b, `PISM_MASK_P0DRV);
      default: ;
    endcase
    bus(1'b1, a, v, b);
  endtask

  task automatic rreg(input logic [11:0] a);
    case (a)
      `PISM_OFS_XTAL:    exp_q.push_back({34'h0, r_x});
      `PISM_OFS_INSEL:   exp_q.push_back({34'h0, r_in});
      `PISM_OFS_TMRSRC:  exp_q.push_back({34'h0, r_ts});
      `PISM_OFS_TMRSEL2: exp_q.push_back({34'h0, r_t2});
      `PISM_OFS_P0DRV:   exp_q.push_back({34'h0, r_d});
      default:           exp_q.push_back({32'h0, 2'h3, 32'h0});
    endcase
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  function automatic logic [65:0] exp_snap();
    pism_pkg::pism_route_t e;
    logic [13:0] st;
    logic [13:0] ed;
    logic [20:0] md;
    logic [3:0]  t2;
    logic [3:0]  t21;
    logic [2:0]  c;
    e.ext_irq_zero = src_sh.ext_irq_zero[r_in[1:0]];
    e.ext_irq_one = src_sh.ext_irq_one[r_in[3:2]];
    e.ext_irq_two = src_sh.ext_irq_two[r_in[5:4]];
    // The receive path and lin_tx are both judged; the transmit pin also needs its port function set.
    e.uart_rx = src_sh.uart_rx[r_in[6]];
    e.lin_tx = r_in[7] ? 1'b1 : src_sh.uart_tx;
    e.serial_slave_out = src_sh.serial_slave_out[r_in[18]];
    e.serial_master_out = src_sh.serial_master_out[r_in[17]];
    e.serial_master_clock = src_sh.serial_master_clock[r_in[16]];
    case (r_t2[9:8])
      2'h0:    t2 = src_sh.timer2_ext_pin;
      2'h1:    t2 = src_sh.monitor;
      2'h2:    t2 = {src_sh.compare_out[1:0], 1'b0, src_sh.lin_rx};
      default: t2 = {src_sh.capture[2], src_sh.capture};
    endcase
    case (r_t2[11:10])
      2'h0:    t21 = src_sh.timer21_ext_pin;
      2'h1:    t21 = src_sh.monitor;
      2'h2:    t21 = {src_sh.capture[1:0], 1'b0, src_sh.lin_rx};
      default: t21 = src_sh.compare_out;
    endcase
    e.timer2_external_input = r_ts[6] ? src_sh.capture[0] : t2[r_t2[5:4]];
    e.timer21_external_input = r_ts[7] ? src_sh.compare_out[0] : t21[r_t2[7:6]];
    e.timer2_count = (r_t2[1:0] == 2'h3) ? 1'b0 : src_sh.timer2_count[r_t2[1:0]];
    e.timer21_count = (r_t2[3:2] == 2'h3) ? 1'b0 : src_sh.timer21_count[r_t2[3:2]];
    for (int n = 0; n < 7; n++) begin
      c = r_d[4*n +: 3];
      md[3*n +: 3] = c;
      st[2*n +: 2] = (c < 3'h3) ? pism_pkg::PISM_DRV_STRONG :
                     (c == 3'h3 || c == 3'h7) ? pism_pkg::PISM_DRV_WEAK : pism_pkg::PISM_DRV_MEDIUM;
      ed[2*n +: 2] = (c < 3'h3) ? c[1:0] : 2'h0;
    end
    return {st, ed, md, e, ~r_in[6], r_x[5:4], r_x[1], r_x[0]};
  endfunction

  task automatic look();
    repeat (6) @(posedge clk_sys_in);
    exp_q.push_back(exp_snap());
    snap <= 1'b1;
    @(posedge clk_sys_in);
    snap <= 1'b0;
  endtask

  task automatic new_src();
    @(posedge clk_sys_in);
    rnd = {$random(seed), $random(seed)};
    src_sh <= rnd[$bits(pism_pkg::pism_src_t)-1:0];
    load <= 1'b1;
    @(posedge clk_sys_in);
    load <= 1'b0;
  endtask

  initial begin
    r_x = `PISM_RST_XTAL;
    r_in = `PISM_RST_ZERO;
    r_ts = `PISM_RST_ZERO;
    r_t2 = `PISM_RST_ZERO;
    r_d = `PISM_RST_ZERO;
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    foreach (offs[k]) rreg(offs[k]);
    rreg(12'h004);
    look();
    $display("test reset values done");
    foreach (offs[k]) begin
      wreg(offs[k], 32'hFFFF_FFFF, 4'hF);
      rreg(offs[k]);
    end
    wreg(12'h004, 32'hFFFF_FFFF, 4'hF);
    rreg(12'h004);
    wreg(`PISM_OFS_INSEL, 32'h0, 4'h1);
    rreg(`PISM_OFS_INSEL);
    look();
    $display("test masks and byte lanes done");
    for (int i = 0; i < 32; i++) begin
      wreg(`PISM_OFS_INSEL, {13'h0, i[2:0], 8'h0, i[3:2], i[1:0], i[1:0], i[1:0]}, 4'hF);
      wreg(`PISM_OFS_TMRSRC, {24'h0, i[4], i[4] ^ i[0], 6'h0}, 4'hF);
      wreg(`PISM_OFS_TMRSEL2, {20'h0, i[3:2], i[3:2], i[1:0], i[1:0], i[1:0], i[1:0]}, 4'hF);
      for (int n = 0; n < 8; n++) d[4*n +: 4] = (n < 7) ? {1'b0, 3'(i + n)} : 4'h0;
      wreg(`PISM_OFS_P0DRV, d, 4'hF);
      // A crystal drives the clock pins here, so hysteresis may stay on.
      wreg(`PISM_OFS_XTAL, {26'h0, i[1:0], 2'h0, i[2], i[3]}, 4'hF);
      new_src();
      look();
      new_src();
      look();
    end
    $display("test routing sweep done");
    tally_and_finish();
  end
endmodule
